// ===== design/hall_pkg.sv
// Shared constants, types and decode functions for the Hall decoder
package hall_pkg;

  // Register map, byte addresses on the Avalon-MM slave
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  CTRL_OFS   = 4'h0;
  localparam logic [3:0]  STATUS_OFS = 4'h4;

  // Leg encoding, one bit per phase leg
  localparam logic [2:0]  LEG_A = 3'h1;
  localparam logic [2:0]  LEG_B = 3'h2;
  localparam logic [2:0]  LEG_C = 3'h4;

  // Control register, bit 0 run, bit 1 phasing, bit 2 half wave
  typedef struct packed {
    logic half_wave;
    logic phasing_60;
    logic run_enable;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = 3'h2;

  // Drive bundle, tops active low, bottoms active high
  typedef struct packed {
    logic [2:0] top_n;
    logic [2:0] bottom;
  } drive_t;
  localparam drive_t DRIVE_OFF = 6'h38;

  // Decoded rotor step
  typedef struct packed {
    logic       valid;
    logic [2:0] index;
  } step_t;

  // Status word as read by software
  typedef struct packed {
    logic [16:0] pad;
    logic [2:0]  bottom;
    logic        gap1;
    logic [2:0]  top_n;
    logic [1:0]  gap0;
    logic        direction;
    logic        thermal;
    logic        valid;
    logic [2:0]  code;
  } status_t;

  // Maps a sensor code (A,B,C) onto a forward step index 0 to 5
  function automatic step_t decode_step(input logic [2:0] code,
                                        input logic       ph60);
    step_t s;
    s.valid = 1'b1;
    s.index = 3'h0;
    if (ph60)
    begin
      unique case (code)
        3'h4: s.index = 3'h0;
        3'h6: s.index = 3'h1;
        3'h7: s.index = 3'h2;
        3'h3: s.index = 3'h3;
        3'h1: s.index = 3'h4;
        3'h0: s.index = 3'h5;
        default: s.valid = 1'b0;
      endcase
    end
    else
    begin
      unique case (code)
        3'h5: s.index = 3'h0;
        3'h4: s.index = 3'h1;
        3'h6: s.index = 3'h2;
        3'h2: s.index = 3'h3;
        3'h3: s.index = 3'h4;
        3'h1: s.index = 3'h5;
        default: s.valid = 1'b0;
      endcase
    end
    return s;
  endfunction : decode_step

  // Top and bottom legs of a step; reverse swaps them
  function automatic drive_t step_drive(input logic [2:0] index,
                                        input logic       fwd);
    logic [2:0] hi;
    logic [2:0] lo;
    drive_t     d;
    hi = LEG_C;
    lo = LEG_B;
    unique case (index)
      3'h0: begin hi = LEG_A; lo = LEG_B; end
      3'h1: begin hi = LEG_A; lo = LEG_C; end
      3'h2: begin hi = LEG_B; lo = LEG_C; end
      3'h3: begin hi = LEG_B; lo = LEG_A; end
      3'h4: begin hi = LEG_C; lo = LEG_A; end
      default: begin hi = LEG_C; lo = LEG_B; end
    endcase
    d.top_n  = fwd ? ~hi : ~lo;
    d.bottom = fwd ? lo : hi;
    return d;
  endfunction : step_drive

endpackage : hall_pkg

// ===== design/hall_commutation_decoder.sv
// Hall-sensor six-step commutation decoder with Avalon-MM registers
// What this block does
// - Full wave: one top, one bottom, different legs
// - Code orders fixed for each phasing convention
// - 300 degree codes are 60 reversed
// - 240 degree codes are 120 reversed
// - Phasing high, direction high: 60 forward
// - Thermal trip turns all drives off
// - Phasing select defaults high, 60/300 decode
// - Full wave drives both winding ends
// - Half wave switches one winding end
// - Invalid code turns all drives off
// - Run enable low turns drives off
// - Top drives are active low
// - Phasing high 60 degrees, low 120
`timescale 1ns/100ps
module hall_commutation_decoder (
  // Clock and reset
  input  wire  logic                          clock_in,
  input  wire  logic                          rst_in,
  // Avalon-MM slave
  input  wire  logic [hall_pkg::ADDR_W-1:0]   avs_address_in,
  input  wire  logic                          avs_read_in,
  input  wire  logic                          avs_write_in,
  input  wire  logic [31:0]                   avs_writedata_in,
  input  wire  logic [3:0]                    avs_byteenable_in,
  output logic       [31:0]                   avs_readdata_out,
  output logic                                avs_waitrequest_out,
  // Sensor and control pins
  input  wire  logic                          position_input_a_in,
  input  wire  logic                          position_input_b_in,
  input  wire  logic                          position_input_c_in,
  input  wire  logic                          rotation_direction_select_in,
  input  wire  logic                          thermal_trip_in,
  // Power switch drives
  output hall_pkg::drive_t                    drive_out
);
  import hall_pkg::*;

  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [2:0] code;
  logic       direction;
  logic       thermal;
  step_t      step;
  drive_t     next_drive;
  ctrl_t      ctrl;
  ctrl_t      next_ctrl;
  logic       next_wait;
  logic [31:0] next_readdata;
  status_t    status;

  // Two-stage synchronisers for the pins
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1 <= 5'h0;
      sync2 <= 5'h0;
    end
    else
    begin
      sync1 <= {thermal_trip_in, rotation_direction_select_in,
                position_input_a_in, position_input_b_in,
                position_input_c_in};
      sync2 <= sync1;
    end
  end

  assign code      = sync2[2:0];
  assign direction = sync2[3];
  assign thermal   = sync2[4];

  // Phasing select chooses the code table
  // phasing picks table
  assign step = decode_step(code, ctrl.phasing_60);

  // Drive selection with all shutdown conditions
  always_comb
  begin
    next_drive = DRIVE_OFF;
    if (!thermal && ctrl.run_enable && step.valid)
    begin
      next_drive = step_drive(step.index, direction);
      if (ctrl.half_wave)
        next_drive.top_n = 3'h7;
    end
  end

  // Drive register, refreshed every cycle
  // updates each clock
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      drive_out <= DRIVE_OFF;
    else
      drive_out <= next_drive;
  end

  // Status view of the decoder
  always_comb
  begin
    status           = '0;
    status.bottom    = drive_out.bottom;
    status.top_n     = drive_out.top_n;
    status.direction = direction;
    status.thermal   = thermal;
    status.valid     = step.valid;
    status.code      = code;
  end

  // Bus slave: one wait cycle, then accept
  always_comb
  begin
    next_wait     = !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    next_ctrl     = ctrl;
    next_readdata = avs_readdata_out;
    if (avs_write_in && !avs_waitrequest_out &&
        avs_address_in == CTRL_OFS && avs_byteenable_in[0])
      next_ctrl = ctrl_t'(avs_writedata_in[2:0]);
    if (avs_read_in && avs_waitrequest_out)
    begin
      unique case (avs_address_in)
        CTRL_OFS:   next_readdata = {29'h0, ctrl};
        STATUS_OFS: next_readdata = 32'(status);
        default:    next_readdata = 32'h0;
      endcase
    end
  end

  // Bus registers
  // phasing resets high
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl                <= CTRL_RESET;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0;
    end
    else
    begin
      ctrl                <= next_ctrl;
      avs_waitrequest_out <= next_wait;
      avs_readdata_out    <= next_readdata;
    end
  end

  // Helpers for the checks
  logic  ctrl_written;
  step_t prev_step;
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_written <= 1'b0;
      prev_step    <= '0;
    end
    else
    begin
      ctrl_written <= ctrl_written || (next_ctrl != ctrl);
      prev_step    <= step;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_thermal_off: assert property (
    thermal |=> drive_out == DRIVE_OFF)
    else $error("drives on during thermal trip");

  a_invalid_off: assert property (
    !step.valid |=> drive_out == DRIVE_OFF)
    else $error("drives on for invalid code");

  a_disable_off: assert property (
    !ctrl.run_enable |=> drive_out.top_n == 3'h7 && drive_out.bottom == 3'h0)
    else $error("drives on while disabled");

  a_one_pair: assert property (
    step.valid && ctrl.run_enable && !thermal && !ctrl.half_wave
    |=> $onehot(~drive_out.top_n) && $onehot(drive_out.bottom)
        && ((~drive_out.top_n & drive_out.bottom) == 3'h0))
    else $error("full wave pair wrong");

  a_half_wave: assert property (
    ctrl.half_wave && step.valid && ctrl.run_enable && !thermal
    |=> drive_out.top_n == 3'h7 && $onehot(drive_out.bottom))
    else $error("half wave drive wrong");

  a_fwd_sixty: assert property (
    ctrl.phasing_60 && code == 3'h4 && direction && ctrl.run_enable
    && !thermal && !ctrl.half_wave
    |=> drive_out.top_n == 3'h6 && drive_out.bottom == 3'h2)
    else $error("forward 60 step wrong");

  a_rev_swap: assert property (
    code == (ctrl.phasing_60 ? 3'h4 : 3'h5) && !direction
    && ctrl.run_enable && !thermal && !ctrl.half_wave
    |=> drive_out.top_n == 3'h5 && drive_out.bottom == 3'h1)
    else $error("reverse step not swapped");

  // One forward step keeps one leg and moves the other
  a_step_seq: assert property (
    step.valid && prev_step.valid && $stable(ctrl) && $stable(direction)
    && step.index == ((prev_step.index == 3'h5) ? 3'h0
                      : prev_step.index + 3'h1)
    && direction && ctrl.run_enable && !thermal && !$past(thermal)
    && !ctrl.half_wave
    |=> (drive_out.top_n == $past(drive_out.top_n))
        != (drive_out.bottom == $past(drive_out.bottom)))
    else $error("forward step changed both legs or none");

  a_phase_default: assert property (
    !ctrl_written |-> ctrl.phasing_60)
    else $error("phasing not high after reset");

  a_bus_ack: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out)
    else $error("bus answer late");

  c_run_forward: cover property (
    step.valid && ctrl.run_enable && direction ##1 drive_out != DRIVE_OFF);
  c_invalid: cover property (!step.valid && ctrl.run_enable);
  c_thermal: cover property (thermal && ctrl.run_enable && step.valid);
  c_half: cover property (ctrl.half_wave && ctrl.run_enable);

endmodule : hall_commutation_decoder

// ===== verif/hall_sensor_model.sv
// Hall sensor model giving the code for each phasing and rotor position
`timescale 1ns/100ps
module hall_sensor_model (
  // Clock for the edge-pulse companion
  input  wire logic       clock_in,
  // Phasing convention and rotor position, 0 to 5
  input  wire logic [1:0] conv_in,
  input  wire logic [2:0] pos_in,
  // Wrong code on demand
  input  wire logic       inject_in,
  input  wire logic [2:0] raw_in,
  // Speed code of the digital speed front end
  input  wire logic [3:0] speed_code_in,
  // Sensor pins
  output logic            a_out,
  output logic            b_out,
  output logic            c_out,
  // Companion outputs: edge pulse and on-time in percent
  output logic            edge_pulse_out,
  output logic [6:0]      on_time_out
);
  logic [2:0] last_code;
  // six codes, fixed order
  // Rows are 60, 300, 120 and 240 degree phasing, codes as {A,B,C}
  localparam logic [2:0] SEQ [4][6] = '{'{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0},
    '{3'h7, 3'h6, 3'h4, 3'h0, 3'h1, 3'h3},
    '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1},
    '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2}};
  // An invalid code appears only while the bench injects one
  assign {a_out, b_out, c_out} = inject_in ? raw_in : SEQ[conv_in][pos_in];

  // one pulse for each change of the sensor code
  always_ff @(posedge clock_in)
  begin
    last_code      <= {a_out, b_out, c_out};
    edge_pulse_out <= ({a_out, b_out, c_out} != last_code);
  end

  // steps of ten percent, full on-time above nine
  assign on_time_out = (speed_code_in > 4'h9) ? 7'h64
                       : {3'h0, speed_code_in} * 7'ha;
endmodule : hall_sensor_model

// ===== verif/testbench.sv
// Self-checking bench for the Hall commutation decoder
`timescale 1ns/100ps
module testbench;
  import hall_pkg::*;
  // One ordinary case: inputs and the drive they should give
  typedef struct packed {
    logic [1:0] conv;
    logic [2:0] pos;
    logic       dir;
    logic       half;
    drive_t     exp;
  } row_t;
  localparam logic [2:0] HI [6] = '{LEG_A, LEG_A, LEG_B, LEG_B, LEG_C, LEG_C};
  localparam logic [2:0] LO [6] = '{LEG_B, LEG_C, LEG_C, LEG_A, LEG_A, LEG_B};
  localparam logic [2:0] BAD [4] = '{3'h2, 3'h5, 3'h0, 3'h7};
  logic        clock;
  logic        rst;
  logic [3:0]  address;
  logic        rd_req;
  logic        wr_req;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic        pa;
  logic        pb;
  logic        pc;
  logic        dir;
  logic        thermal;
  drive_t      drive;
  logic [1:0]  conv;
  logic [2:0]  pos;
  logic        inject;
  logic [2:0]  raw;
  logic [3:0]  speed_code;
  logic        edge_pulse;
  logic [6:0]  on_time;
  logic [31:0] rd;
  row_t        rows [96];
  int          errors;
  int          check_count;
  int          idx;
  int          pulses = 0;
  int          p0;

  hall_commutation_decoder hall_commutation_decoder_inst (
    .clock_in                     (clock),
    .rst_in                       (rst),
    .avs_address_in               (address),
    .avs_read_in                  (rd_req),
    .avs_write_in                 (wr_req),
    .avs_writedata_in             (wdata),
    .avs_byteenable_in            (be),
    .avs_readdata_out             (rdata),
    .avs_waitrequest_out          (waitreq),
    .position_input_a_in          (pa),
    .position_input_b_in          (pb),
    .position_input_c_in          (pc),
    .rotation_direction_select_in (dir),
    .thermal_trip_in              (thermal),
    .drive_out                    (drive)
  );

  hall_sensor_model hall_sensor_model_inst (
    .clock_in       (clock),
    .conv_in        (conv),
    .pos_in         (pos),
    .inject_in      (inject),
    .raw_in         (raw),
    .speed_code_in  (speed_code),
    .a_out          (pa),
    .b_out          (pb),
    .c_out          (pc),
    .edge_pulse_out (edge_pulse),
    .on_time_out    (on_time)
  );

  // Companion pulses seen at each rising edge
  always @(posedge clock)
    if (edge_pulse === 1'b1)
      pulses <= pulses + 1;

  // Free-running 25 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Counts, verdict and end of run
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Compare and report a mismatch at once
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] adr,
                     input logic [31:0] wd, input logic [3:0] ben);
    int n;
    n = 0;
    address <= adr;
    wr_req  <= wr;
    rd_req  <= ~wr;
    wdata   <= wd;
    be      <= ben;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0)
    begin
      errors++;
      finish_test();
    end
    rd = rdata;
    rd_req <= 1'b0;
    wr_req <= 1'b0;
    @(posedge clock);
  endtask : bus

  // Expected drive of a forward step index
  function automatic drive_t exp_drive(input int i, input logic fwd,
                                       input logic half);
    drive_t d;
    // full wave both ends, half wave bottoms only
    d.top_n  = half ? 3'h7 : ~(fwd ? HI[i] : LO[i]);
    d.bottom = fwd ? LO[i] : HI[i];
    return d;
  endfunction : exp_drive

  // Reset, then table rows, then the awkward cases
  initial
  begin
    {rst, dir} = 2'h3;
    {address, rd_req, wr_req, wdata, be} = '0;
    {thermal, conv, pos, inject, raw, speed_code} = '0;
    errors = 0;
    check_count = 0;
    for (int i = 0; i < 96; i++)
    begin
      rows[i].conv = 2'(i / 24);
      rows[i].pos  = 3'((i / 4) % 6);
      rows[i].dir  = i[1];
      rows[i].half = i[0];
      idx = rows[i].conv[0] ? (8 - rows[i].pos) % 6 : rows[i].pos;
      rows[i].exp = exp_drive(idx, rows[i].dir, rows[i].half);
    end
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(32'(drive), 32'h38);
    bus(1'b0, CTRL_OFS, '0, 4'hf);
    check(rd, 32'h2);
    bus(1'b1, CTRL_OFS, 32'h1, 4'h0);
    bus(1'b0, CTRL_OFS, '0, 4'hf);
    check(rd, 32'h2);
    bus(1'b0, 4'h8, '0, 4'hf);
    check(rd, 32'h0);
    foreach (rows[i])
    begin
      bus(1'b1, CTRL_OFS, {29'h0, rows[i].half, ~rows[i].conv[1], 1'b1}, 4'hf);
      conv <= rows[i].conv;
      pos  <= rows[i].pos;
      // direction level chosen by the controller
      dir  <= rows[i].dir;
      repeat (4) @(posedge clock);
      check(32'(drive), 32'(rows[i].exp));
    end
    bus(1'b1, CTRL_OFS, 32'h3, 4'hf);
    {conv, pos, dir, thermal} <= 7'h3;
    repeat (4) @(posedge clock);
    check(32'(drive), 32'h38);
    thermal <= 1'b0;
    repeat (4) @(posedge clock);
    check(32'(drive), 32'(exp_drive(0, 1'b1, 1'b0)));
    bus(1'b0, STATUS_OFS, '0, 4'hf);
    check(rd, 32'h262c);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, CTRL_OFS, (i < 2) ? 32'h3 : 32'h1, 4'hf);
      inject <= 1'b1;
      raw    <= BAD[i];
      repeat (4) @(posedge clock);
      check(32'(drive), 32'h38);
    end
    inject <= 1'b0;
    bus(1'b1, CTRL_OFS, 32'h2, 4'hf);
    repeat (4) @(posedge clock);
    check(32'(drive), 32'h38);
    // Forward sweep through all six 60 degree codes
    bus(1'b1, CTRL_OFS, 32'h3, 4'hf);
    {conv, pos, dir} <= 6'h1;
    repeat (4) @(posedge clock);
    p0 = pulses;
    for (int s = 1; s <= 6; s++)
    begin
      pos <= 3'(s % 6);
      repeat (4) @(posedge clock);
      check(32'(drive), 32'(exp_drive(s % 6, 1'b1, 1'b0)));
    end
    check(32'(pulses - p0), 32'h6);
    // Speed front end: ten percent steps, then full on-time
    for (int k = 0; k < 16; k++)
    begin
      speed_code <= 4'(k);
      @(posedge clock);
      check(32'(on_time), (k < 10) ? 32'(k * 10) : 32'h64);
    end
    // Reset in mid-run: drives off at once, control back to default
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    check(32'(drive), 32'h38);
    rst <= 1'b0;
    @(posedge clock);
    bus(1'b0, CTRL_OFS, '0, 4'hf);
    check(rd, 32'h2);
    finish_test();
  end
endmodule : testbench
